// File: hdl/amb_pkg.sv
// shared constants and types for the active message buffer window
package amb_pkg;

    // ==========
    // buffer geometry
    localparam int AMB_NUM_BUF = 4;
    localparam int AMB_BUF_IDX_W = 2;
    localparam logic [6:0] AMB_BUF_WORDS = 7'h14;
    localparam int AMB_MEM_DEPTH = AMB_NUM_BUF * int'(AMB_BUF_WORDS);
    localparam int AMB_MEM_AW = 7;
    localparam int AMB_MAX_PAYLOAD_BYTES = 32;
    localparam int AMB_BYTES_PER_WORD = 2;
    localparam logic [6:0] AMB_MAX_PAYLOAD_WORDS =
        7'(AMB_MAX_PAYLOAD_BYTES / AMB_BYTES_PER_WORD);

    // ==========
    // word positions inside one buffer
    localparam logic [4:0] AMB_W_FRAME_ID = 5'h00;
    localparam logic [4:0] AMB_W_CYC_LEN = 5'h01;
    localparam logic [4:0] AMB_W_HDR_CHK = 5'h02;
    localparam logic [4:0] AMB_W_DATA0 = 5'h03;
    localparam logic [4:0] AMB_W_DATA15 = 5'h12;
    localparam logic [4:0] AMB_W_SLOT = 5'h13;

    // ==========
    // field layouts
    localparam int AMB_RES_FLAG_BIT = 15;
    localparam int AMB_PP_BIT = 14;
    localparam int AMB_NFI_BIT = 13;
    localparam int AMB_SYNC_BIT = 12;
    localparam int AMB_STARTUP_BIT = 11;
    localparam logic [15:0] AMB_FID_MASK = 16'h07FF;
    localparam logic [15:0] AMB_CYC_MASK = 16'h3F00;
    localparam logic [15:0] AMB_LEN_MASK = 16'h007F;
    localparam logic [15:0] AMB_HCRC_MASK = 16'h07FF;
    localparam logic [15:0] AMB_SLOT_MASK = 16'h01FF;

    // ==========
    // register byte offsets outside the window
    localparam logic [7:0] AMB_OFS_CTRL = 8'h80;
    localparam logic [7:0] AMB_OFS_LOCK = 8'h84;
    localparam logic [7:0] AMB_OFS_ISTAT = 8'h88;
    localparam logic [7:0] AMB_OFS_IMASK = 8'h8C;
    localparam logic [7:0] AMB_OFS_BUFCFG = 8'h90;
    localparam int AMB_LOCK_REQ_BIT = 8;
    localparam int AMB_CFG_DYN_BIT = 2;
    localparam int AMB_CFG_CCOWN_BIT = 3;

    // ==========
    // reset values
    localparam logic AMB_CTRL_CFG_RST = 1'b1;
    localparam logic [3:0] AMB_BUFCFG_RST = 4'h0;
    localparam logic [2:0] AMB_IMASK_RST = 3'h0;

    // ==========
    // interrupt bits
    localparam int AMB_IRQ_W = 3;
    localparam int AMB_IRQ_LOCK = 0;
    localparam int AMB_IRQ_ACCESS = 1;
    localparam int AMB_IRQ_LEN = 2;

    // ==========
    // bus answers
    localparam logic [1:0] AMB_RESP_OKAY = 2'h0;
    localparam logic [1:0] AMB_RESP_SLVERR = 2'h2;
    localparam logic [1:0] AMB_RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        AMB_KIND_RX = 2'h0,
        AMB_KIND_TX = 2'h1,
        AMB_KIND_FIFO = 2'h2
    } amb_kind_t;

    typedef enum logic [2:0] {
        AMB_ST_IDLE = 3'h0,
        AMB_ST_RRD = 3'h1,
        AMB_ST_RDAT = 3'h3,
        AMB_ST_RRESP = 3'h2,
        AMB_ST_WRD = 3'h6,
        AMB_ST_WMRG = 3'h7,
        AMB_ST_BRESP = 3'h5
    } amb_state_t;

endpackage

// File: hdl/amb_msg_ram.sv
// buffer word storage with one write port and a registered read port
`timescale 1ns/1ps
module amb_msg_ram
    import amb_pkg::*;
(
    input wire logic aclk,
    input wire logic we,
    input wire logic [AMB_MEM_AW-1:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [AMB_MEM_AW-1:0] raddr,
    output logic [15:0] rdata
);

    logic [15:0] mem [AMB_MEM_DEPTH];

    // ==========================================================
    // storage has no reset; contents are set up by software
    always_ff @(posedge aclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

// File: hdl/amb_field_access.sv
// per-word host read and write masks of the active window
`timescale 1ns/1ps
module amb_field_access
    import amb_pkg::*;
(
    input wire logic [4:0] word,
    input wire amb_kind_t kind,
    input wire logic dynamic,
    input wire logic config_state,
    output logic [15:0] wr_mask,
    output logic [15:0] rd_mask
);

    logic is_tx;
    logic tx_policy_ok;

    assign is_tx = (kind == AMB_KIND_TX);
    assign tx_policy_ok = config_state || dynamic;

    always_comb
    begin
        rd_mask = 16'hFFFF;
        wr_mask = 16'h0000;
        case (word)
            AMB_W_FRAME_ID:
            begin
                if (is_tx)
                begin
                    // flag bits 13..11 are unused for transmit and stay read-only
                    wr_mask[AMB_RES_FLAG_BIT] = 1'b1;
                    if (tx_policy_ok)
                    begin
                        wr_mask = wr_mask | AMB_FID_MASK;
                        wr_mask[AMB_PP_BIT] = 1'b1;
                    end
                end
                else if (config_state)
                begin
                    wr_mask = AMB_FID_MASK;
                end
            end
            AMB_W_CYC_LEN:
            begin
                rd_mask = AMB_CYC_MASK | AMB_LEN_MASK;
                if (is_tx && tx_policy_ok)
                begin
                    wr_mask = AMB_LEN_MASK;
                end
            end
            AMB_W_HDR_CHK:
            begin
                rd_mask = AMB_HCRC_MASK;
                if (is_tx && tx_policy_ok)
                begin
                    wr_mask = AMB_HCRC_MASK;
                end
            end
            AMB_W_SLOT:
            begin
                rd_mask = AMB_SLOT_MASK;
            end
            default:
            begin
                if (word >= AMB_W_DATA0 && word <= AMB_W_DATA15)
                begin
                    wr_mask = is_tx ? 16'hFFFF : 16'h0000;
                end
                else
                begin
                    rd_mask = 16'h0000;
                end
            end
        endcase
    end

endmodule

// File: hdl/amb_window.sv
// active message buffer window: AXI4-Lite slave, buffer storage, access rights
`timescale 1ns/1ps
module amb_window
    import amb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cc_wr_en,
    input wire logic [AMB_BUF_IDX_W-1:0] cc_wr_buf,
    input wire logic [4:0] cc_wr_word,
    input wire logic [15:0] cc_wr_data,
    output logic cc_config_state,
    output logic cc_host_locked,
    output logic [AMB_BUF_IDX_W-1:0] cc_host_buf,
    output logic irq
);

    // ==========
    // state and registers
    amb_state_t state_r;
    amb_state_t state_nxt;
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] aw_addr_r;
    logic [15:0] w_data_r;
    logic [1:0] w_strb_r;
    logic [7:0] addr_r;
    logic [1:0] resp_r;
    logic [15:0] rdata_r;
    logic cfg_state_r;
    logic locked_r;
    logic [AMB_BUF_IDX_W-1:0] active_r;
    logic [3:0] buf_cfg_r [AMB_NUM_BUF];
    logic [AMB_IRQ_W-1:0] irq_stat_r;
    logic [AMB_IRQ_W-1:0] irq_mask_r;

    // ==========
    // address decode
    logic [4:0] word_idx;
    logic win_hit;
    logic is_ctrl;
    logic is_lock;
    logic is_istat;
    logic is_imask;
    logic is_bufcfg;
    logic [AMB_BUF_IDX_W-1:0] cfg_sel;
    logic reg_hit;

    assign word_idx = addr_r[6:2];
    assign win_hit = !addr_r[7] && (word_idx <= AMB_W_SLOT);
    assign is_ctrl = (addr_r == AMB_OFS_CTRL);
    assign is_lock = (addr_r == AMB_OFS_LOCK);
    assign is_istat = (addr_r == AMB_OFS_ISTAT);
    assign is_imask = (addr_r == AMB_OFS_IMASK);
    assign cfg_sel = addr_r[2+AMB_BUF_IDX_W-1:2];
    assign is_bufcfg = (addr_r[7:4] == AMB_OFS_BUFCFG[7:4]) && (addr_r[1:0] == 2'h0);
    assign reg_hit = is_ctrl || is_lock || is_istat || is_imask || is_bufcfg;

    // ==========
    // active buffer properties
    amb_kind_t act_kind;
    logic act_dyn;
    logic act_ccown;
    logic act_ok;

    assign act_kind = amb_kind_t'(buf_cfg_r[active_r][1:0]);
    assign act_dyn = buf_cfg_r[active_r][AMB_CFG_DYN_BIT];
    assign act_ccown = buf_cfg_r[active_r][AMB_CFG_CCOWN_BIT];
    // a later reconfiguration can still mark a locked buffer as controller-owned
    assign act_ok = locked_r && !(act_kind == AMB_KIND_TX && act_ccown);

    // ==========
    // storage and field rights
    logic [AMB_MEM_AW-1:0] host_maddr;
    logic [AMB_MEM_AW-1:0] cc_maddr;
    logic [15:0] mem_rdata;
    logic [15:0] wr_mask;
    logic [15:0] rd_mask;
    logic [15:0] strb_mask;
    logic [15:0] eff_mask;
    logic [15:0] merged;
    logic mem_we;
    logic [AMB_MEM_AW-1:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic host_we;
    logic cc_clash;
    logic len_bad;

    assign host_maddr = AMB_MEM_AW'(active_r) * AMB_BUF_WORDS + AMB_MEM_AW'(word_idx);
    assign cc_maddr = AMB_MEM_AW'(cc_wr_buf) * AMB_BUF_WORDS + AMB_MEM_AW'(cc_wr_word);

    amb_field_access u_access (
        .word(word_idx),
        .kind(act_kind),
        .dynamic(act_dyn),
        .config_state(cfg_state_r),
        .wr_mask(wr_mask),
        .rd_mask(rd_mask)
    );

    assign strb_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    assign eff_mask = wr_mask & strb_mask;
    // byte 2n lands in the low lane, byte 2n+1 in the high lane
    assign merged = (mem_rdata & ~eff_mask) | (w_data_r & eff_mask);
    // length is in two-byte words, so 32 bytes caps it at 16
    assign len_bad = (act_kind == AMB_KIND_TX) && (word_idx == AMB_W_CYC_LEN)
        && ((merged & AMB_LEN_MASK) > {9'h000, AMB_MAX_PAYLOAD_WORDS});

    // the controller wins the port; a clash on the same word redoes the merge
    assign cc_clash = cc_wr_en && (cc_maddr == host_maddr);
    assign host_we = (state_r == AMB_ST_WMRG) && !cc_wr_en && !len_bad;
    assign mem_we = cc_wr_en || host_we;
    assign mem_waddr = cc_wr_en ? cc_maddr : host_maddr;
    assign mem_wdata = cc_wr_en ? cc_wr_data : merged;

    amb_msg_ram u_ram (
        .aclk(aclk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(host_maddr),
        .rdata(mem_rdata)
    );

    // ==========
    // register write decode (taken in the first write state)
    logic reg_wr;
    logic lock_wr;
    logic lock_req;
    logic [AMB_BUF_IDX_W-1:0] lock_idx;
    logic lock_refuse;
    logic cfg_wr;

    assign reg_wr = (state_r == AMB_ST_WRD) && reg_hit && w_strb_r[0];
    assign lock_wr = reg_wr && is_lock && w_strb_r[1];
    assign lock_req = w_data_r[AMB_LOCK_REQ_BIT];
    assign lock_idx = w_data_r[AMB_BUF_IDX_W-1:0];
    assign lock_refuse = lock_wr && lock_req
        && (buf_cfg_r[lock_idx][1:0] == AMB_KIND_TX)
        && buf_cfg_r[lock_idx][AMB_CFG_CCOWN_BIT];
    // buffer setup belongs to the config-only write class
    assign cfg_wr = reg_wr && is_bufcfg && cfg_state_r;

    // ==========
    // events and interrupt
    logic [AMB_IRQ_W-1:0] ev;
    logic [AMB_IRQ_W-1:0] irq_clr;
    logic win_deny_wr;
    logic win_deny_rd;

    assign win_deny_wr = (state_r == AMB_ST_WRD) && win_hit && !act_ok;
    assign win_deny_rd = (state_r == AMB_ST_RDAT) && win_hit && !act_ok;
    assign ev[AMB_IRQ_LOCK] = lock_refuse;
    assign ev[AMB_IRQ_ACCESS] = win_deny_wr || win_deny_rd;
    assign ev[AMB_IRQ_LEN] = (state_r == AMB_ST_WMRG) && len_bad;
    assign irq_clr = ((state_r == AMB_ST_RDAT) && is_istat) ? irq_stat_r : '0;
    assign irq = |(irq_stat_r & irq_mask_r);

    // ==========
    // read data selection
    logic [15:0] rd_sel;
    logic [1:0] rd_resp;

    always_comb
    begin
        rd_sel = 16'h0000;
        rd_resp = AMB_RESP_OKAY;
        if (win_hit)
        begin
            if (act_ok)
            begin
                // reserved bits read as zero whatever the storage holds
                rd_sel = mem_rdata & rd_mask;
            end
            else
            begin
                rd_resp = AMB_RESP_SLVERR;
            end
        end
        else if (is_ctrl)
        begin
            rd_sel = {15'h0000, cfg_state_r};
        end
        else if (is_lock)
        begin
            rd_sel = {7'h00, locked_r, 6'h00, active_r};
        end
        else if (is_istat)
        begin
            rd_sel = {13'h0000, irq_stat_r};
        end
        else if (is_imask)
        begin
            rd_sel = {13'h0000, irq_mask_r};
        end
        else if (is_bufcfg)
        begin
            rd_sel = {12'h000, buf_cfg_r[cfg_sel]};
        end
        else
        begin
            rd_resp = AMB_RESP_DECERR;
        end
    end

    // ==========
    // transaction sequencer
    logic wr_go;

    assign wr_go = aw_have_r && w_have_r;
    assign s_axi_awready = !aw_have_r;
    assign s_axi_wready = !w_have_r;
    assign s_axi_arready = (state_r == AMB_ST_IDLE) && !wr_go;
    assign s_axi_bvalid = (state_r == AMB_ST_BRESP);
    assign s_axi_rvalid = (state_r == AMB_ST_RRESP);
    assign s_axi_bresp = resp_r;
    assign s_axi_rresp = resp_r;
    assign s_axi_rdata = {16'h0000, rdata_r};

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            AMB_ST_IDLE:
            begin
                if (wr_go)
                begin
                    state_nxt = AMB_ST_WRD;
                end
                else if (s_axi_arvalid)
                begin
                    state_nxt = AMB_ST_RRD;
                end
            end
            AMB_ST_RRD:
            begin
                state_nxt = AMB_ST_RDAT;
            end
            AMB_ST_RDAT:
            begin
                state_nxt = AMB_ST_RRESP;
            end
            AMB_ST_RRESP:
            begin
                if (s_axi_rready)
                begin
                    state_nxt = AMB_ST_IDLE;
                end
            end
            AMB_ST_WRD:
            begin
                state_nxt = (win_hit && act_ok) ? AMB_ST_WMRG : AMB_ST_BRESP;
            end
            AMB_ST_WMRG:
            begin
                if (cc_clash)
                begin
                    state_nxt = AMB_ST_WRD;
                end
                else if (!cc_wr_en)
                begin
                    state_nxt = AMB_ST_BRESP;
                end
            end
            AMB_ST_BRESP:
            begin
                if (s_axi_bready)
                begin
                    state_nxt = AMB_ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = AMB_ST_IDLE;
            end
        endcase
    end

    // ==========
    // write response code, set in the first write state; a length error in the merge state turns it to SLVERR
    logic [1:0] wr_resp;

    assign wr_resp = win_hit ? (act_ok ? AMB_RESP_OKAY : AMB_RESP_SLVERR)
        : (reg_hit ? (lock_refuse ? AMB_RESP_SLVERR : AMB_RESP_OKAY) : AMB_RESP_DECERR);

    // ==========
    // bus capture registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= AMB_ST_IDLE;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 16'h0000;
            w_strb_r <= 2'h0;
            addr_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                aw_have_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata[15:0];
                w_strb_r <= s_axi_wstrb[1:0];
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                w_have_r <= 1'b0;
            end
            if (state_r == AMB_ST_IDLE && wr_go)
            begin
                addr_r <= aw_addr_r;
            end
            else if (s_axi_arvalid && s_axi_arready)
            begin
                addr_r <= {s_axi_araddr[7:2], 2'h0};
            end
        end
    end

    // ==========
    // answer registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            resp_r <= AMB_RESP_OKAY;
            rdata_r <= 16'h0000;
        end
        else if (state_r == AMB_ST_RDAT)
        begin
            resp_r <= rd_resp;
            rdata_r <= rd_sel;
        end
        else if (state_r == AMB_ST_WRD)
        begin
            resp_r <= wr_resp;
        end
        else if (state_r == AMB_ST_WMRG && len_bad)
        begin
            resp_r <= AMB_RESP_SLVERR;
        end
    end

    // ==========
    // control registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_state_r <= AMB_CTRL_CFG_RST;
            locked_r <= 1'b0;
            active_r <= '0;
            irq_mask_r <= AMB_IMASK_RST;
            irq_stat_r <= '0;
        end
        else
        begin
            if (reg_wr && is_ctrl)
            begin
                cfg_state_r <= w_data_r[0];
            end
            if (reg_wr && is_imask)
            begin
                irq_mask_r <= w_data_r[AMB_IRQ_W-1:0];
            end
            if (lock_wr)
            begin
                locked_r <= lock_req && !lock_refuse;
                active_r <= lock_idx;
            end
            // a new event wins over a read-clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~irq_clr) | ev;
        end
    end

    // ==========
    // per-buffer configuration
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < AMB_NUM_BUF; i++)
            begin
                buf_cfg_r[i] <= AMB_BUFCFG_RST;
            end
        end
        else if (cfg_wr)
        begin
            buf_cfg_r[cfg_sel] <= w_data_r[3:0];
        end
    end

    assign cc_config_state = cfg_state_r;
    assign cc_host_locked = locked_r;
    assign cc_host_buf = active_r;

endmodule

// File: tb/amb_window_assertions.sv
// concurrent checks on the active window ports
`timescale 1ns/1ps
module amb_window_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic cc_config_state,
    input wire logic cc_host_locked
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // bus timing and held answers
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |-> ##3 s_axi_rvalid)
        else $error("read answer late");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[3:4] s_axi_bvalid)
        else $error("write answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during answer");
    AST_RD_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half set");
    // ==========================================================
    // state changes only through a completed register write
    AST_LOCK_CHG: assert property (!$stable(cc_host_locked) |-> s_axi_bvalid)
        else $error("lock changed without write");
    AST_CFG_CHG: assert property (!$stable(cc_config_state) |-> s_axi_bvalid)
        else $error("state changed without write");
endmodule
bind amb_window amb_window_chk amb_window_chk_inst (.*);

// File: tb/amb_host_model.sv
// host bus master model driving the window's AXI4-Lite port
`timescale 1ns/1ps
module amb_host_model (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // slow answers accept a response one cycle after it shows
    bit slow = 1'h0;
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'h0;
        w = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h3;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= !slow;
        do
        begin
            @(posedge aclk);
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
            // released lines stop showing the old value
            if (aw) s_axi_awaddr <= ~a;
            if (w) s_axi_wdata <= ~d;
        end
        while (!(aw && w));
        while (!(s_axi_bvalid && s_axi_bready))
        begin
            s_axi_bready <= !slow || s_axi_bvalid;
            @(posedge aclk);
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= !slow;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        s_axi_araddr <= ~a;
        while (!(s_axi_rvalid && s_axi_rready))
        begin
            s_axi_rready <= !slow || s_axi_rvalid;
            @(posedge aclk);
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
endmodule

// File: tb/active_message_buffer_window_tb.sv
// self-checking bench for the active message buffer window
`timescale 1ns/1ps
module active_message_buffer_window_tb
    import amb_pkg::*;
;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, cc_host_buf, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    logic cc_config_state, cc_host_locked, cc_wr_en = 1'h0;
    logic [1:0] cc_wr_buf = 2'h0;
    logic [4:0] cc_wr_word = 5'h00;
    logic [15:0] cc_wr_data = 16'h0000;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    amb_window amb_window_inst (.*);
    amb_host_model amb_host_model_inst (.*);
    initial forever #12.5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            results();
        end
    end
    // ==========================================================
    // compare, bus and expectation helpers
    task automatic results();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (e !== g)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkr(input string nm, input logic [1:0] e, input logic [1:0] g);
        chk(nm, 32'(e), 32'(g));
    endtask
    task automatic wrc(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er);
        amb_host_model_inst.wr(a, {16'h0000, v}, r);
        chkr("bresp", er, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] ev, input logic [1:0] er);
        amb_host_model_inst.rd(a, d, r);
        chkr("rresp", er, r);
        chk("rdata", {16'h0000, ev}, d);
    endtask
    task automatic ccw(input logic [1:0] b, input logic [4:0] w, input logic [15:0] v);
        @(posedge aclk);
        {cc_wr_en, cc_wr_buf, cc_wr_word, cc_wr_data} <= {1'h1, b, w, v};
        @(posedge aclk);
        cc_wr_en <= 1'h0;
    endtask
    function automatic logic [15:0] mrg(input logic [15:0] o, v, m);
        return (o & ~m) | (v & m);
    endfunction
    // ==========================================================
    // main sequence
    initial
    begin
        logic [15:0] v, w0, w2;
        void'($urandom(12118));
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk("config", 1, cc_config_state);
        rdc(8'hA0, 16'h0000, AMB_RESP_DECERR);
        rdc(8'h00, 16'h0000, AMB_RESP_SLVERR);
        chk("irq masked", 0, irq);
        rdc(AMB_OFS_ISTAT, 16'h0002, AMB_RESP_OKAY);
        wrc(AMB_OFS_IMASK, 16'h0007, AMB_RESP_OKAY);
        wrc(8'h94, 16'h0001, AMB_RESP_OKAY);
        wrc(8'h98, 16'h0009, AMB_RESP_OKAY);
        wrc(8'h9C, 16'h0005, AMB_RESP_OKAY);
        rdc(8'h98, 16'h0009, AMB_RESP_OKAY);
        wrc(AMB_OFS_LOCK, 16'h0102, AMB_RESP_SLVERR);
        @(posedge aclk);
        chk("irq", 1, irq);
        rdc(AMB_OFS_ISTAT, 16'h0001, AMB_RESP_OKAY);
        @(posedge aclk);
        chk("irq clear", 0, irq);
        rdc(8'h00, 16'h0000, AMB_RESP_SLVERR);
        rdc(AMB_OFS_ISTAT, 16'h0002, AMB_RESP_OKAY);
        $display("test lock done");
        for (int k = 0; k < 40; k++) ccw(k < 20 ? 2'h1 : 2'h3, 5'(k % 20), 16'h0000);
        wrc(AMB_OFS_LOCK, 16'h0101, AMB_RESP_OKAY);
        chk("buf", 1, cc_host_buf);
        chk("locked", 1, cc_host_locked);
        v = 16'($urandom);
        w0 = v & 16'hC7FF;
        wrc(8'h00, v, AMB_RESP_OKAY);
        rdc(8'h00, w0, AMB_RESP_OKAY);
        v = (16'($urandom) & 16'hFF80) | 16'($urandom_range(16, 0));
        wrc(8'h04, v, AMB_RESP_OKAY);
        wrc(8'h04, 16'h0011, AMB_RESP_SLVERR);
        rdc(8'h04, v & 16'h007F, AMB_RESP_OKAY);
        rdc(AMB_OFS_ISTAT, 16'h0004, AMB_RESP_OKAY);
        v = 16'($urandom);
        w2 = v & 16'h07FF;
        wrc(8'h08, v, AMB_RESP_OKAY);
        rdc(8'h08, w2, AMB_RESP_OKAY);
        for (int k = 0; k < 16; k++)
        begin
            v = 16'($urandom);
            wrc(8'(8'h0C + 4 * k), v, AMB_RESP_OKAY);
            rdc(8'(8'h0C + 4 * k), v, AMB_RESP_OKAY);
        end
        v = 16'($urandom);
        ccw(2'h1, 5'h13, v);
        wrc(8'h4C, ~v, AMB_RESP_OKAY);
        rdc(8'h4C, v & 16'h01FF, AMB_RESP_OKAY);
        ccw(2'h1, 5'h03, ~v);
        rdc(8'h0C, ~v, AMB_RESP_OKAY);
        $display("test config done");
        wrc(AMB_OFS_CTRL, 16'h0000, AMB_RESP_OKAY);
        chk("config", 0, cc_config_state);
        v = 16'($urandom);
        wrc(8'h00, v, AMB_RESP_OKAY);
        rdc(8'h00, mrg(w0, v, 16'h8000), AMB_RESP_OKAY);
        wrc(8'h08, ~w2, AMB_RESP_OKAY);
        rdc(8'h08, w2, AMB_RESP_OKAY);
        wrc(8'h94, 16'h0000, AMB_RESP_OKAY);
        rdc(8'h94, 16'h0001, AMB_RESP_OKAY);
        amb_host_model_inst.slow = 1'h1;
        wrc(AMB_OFS_LOCK, 16'h0103, AMB_RESP_OKAY);
        v = 16'($urandom);
        wrc(8'h08, v, AMB_RESP_OKAY);
        rdc(8'h08, v & 16'h07FF, AMB_RESP_OKAY);
        $display("test normal done");
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        chk("locked", 0, cc_host_locked);
        chk("config", 1, cc_config_state);
        aresetn <= 1'h1;
        $display("test reset done");
        results();
    end
endmodule
